/* design/pgmp_port.sv */
// seven-line general-purpose port with alternative function multiplexing
`timescale 1ns/1ps
module pgmp_port #(
  parameter int DEB_TICK_CYCLES = pgmp_pkg::DEB_TICK_CYC
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // pads
  input  wire logic [6:0]           pad_in,
  output logic      [6:0]           pad_out,
  output logic      [6:0]           pad_oe,
  output logic      [6:0]           pad_pull_up,
  output logic      [6:0]           pad_pull_down,
  // function selection
  input  wire logic [6:0]           pad_function_select_a,
  input  wire logic [13:0]          pad_function_select_b,
  // plain mode control
  input  wire logic                 gpio_enable,
  input  wire logic [6:0]           line_direction,
  input  wire logic                 line_out_wr_en,
  input  wire logic [6:0]           line_out_wr_data,
  input  wire logic [6:0]           line_out_set,
  input  wire logic [6:0]           line_out_clear,
  output logic      [6:0]           line_out_state,
  output logic      [6:0]           line_in_state,
  input  wire logic [6:0]           line_debounce_enable,
  input  wire logic [6:0]           line_pull_config_a,
  input  wire logic [6:0]           line_pull_config_b,
  input  wire logic [6:0]           line_open_drain_enable,
  // alternative mode pad settings
  input  wire logic [6:0]           alt_pull_up,
  input  wire logic [6:0]           alt_pull_down,
  input  wire logic [6:0]           alt_open_drain,
  // line events
  input  wire logic [6:0]           irq_rise_enable,
  input  wire logic [6:0]           irq_fall_enable,
  input  wire logic [6:0]           irq_mask,
  input  wire logic [6:0]           irq_clear,
  output logic      [6:0]           irq_status,
  input  wire logic [6:0]           wake_enable,
  input  wire logic                 off_mode,
  output logic                      wake_request,
  // device core side of the alternatives
  input  wire logic                 ext_supply_en_a,
  input  wire logic                 ext_supply_en_b,
  input  wire logic                 ext_supply_en_c,
  input  wire logic                 supplies_valid_out,
  input  wire logic                 scaling_link_data_oe,
  output logic                      scaling_link_data,
  output logic                      scaling_link_clock,
  output logic                      power_off_request_in,
  output logic                      periph_power_req_a,
  output logic                      periph_power_req_b,
  output logic                      reset_in,
  output logic                      warm_reset_in_n,
  output logic                      bus_supply_detect_in,
  output logic                      converter_sync_in,
  output logic                      keep_on_in,
  output logic                      sleep_request_in_n
);
  import pgmp_pkg::*;

  // ****************************************
  // elaboration checks
  // ****************************************
  generate
    if (DEB_TICK_CYCLES < 1 || DEB_TICK_CYCLES >= (1 << TICK_W)) begin : g_bad
      $error("debounce tick period out of range");
    end
  endgenerate

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(DEB_TICK_CYCLES - 1);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [6:0]        sync1;
    logic [6:0]        sync2;
    logic [6:0]        prev;
    logic [6:0]        out_data;
    logic [6:0]        in_state;
    logic [6:0]        status;
    logic [6:0]        drv_out;
    logic [6:0]        drv_oe;
    logic [6:0]        pull_up;
    logic [6:0]        pull_dn;
    logic              wake;
    logic [TICK_W-1:0] tick_cnt;
    logic              link_da;
    logic              link_ck;
    logic              pwr_off;
    logic              preq_a;
    logic              preq_b;
    logic              rst_in;
    logic              warm_n;
    logic              bus_det;
    logic              sync_in;
    logic              keep_on;
    logic              sleep_n;
  } pgmp_st_t;

  pgmp_st_t st;
  pgmp_st_t next_st;

  // true when a line is in alternative mode with the given code
  function automatic logic alt_is(input logic [6:0] sec,
                                  input logic [13:0] code_vec,
                                  input int ln,
                                  input logic [1:0] code);
    alt_is = sec[ln] && (code_vec[SEL_W*ln +: SEL_W] == code);
  endfunction

  // ****************************************
  // debounce
  // ****************************************
  logic       tick;
  logic [6:0] deb_lvl;
  logic [6:0] filt;

  assign tick = (st.tick_cnt == TICK_LAST);

  genvar gi;
  generate
    for (gi = 0; gi < NL; gi++) begin : g_deb
      pgmp_debounce #(
        .SAMPLES (DEB_SAMPLES)
      ) u_deb (
        .sys_clk (sys_clk),
        .rst     (rst),
        .tick    (tick),
        .raw     (st.sync2[gi]),
        .level   (deb_lvl[gi])
      );
    end
  endgenerate

  // debounced where enabled, else synchronised level
  assign filt = (line_debounce_enable & deb_lvl)
              | (~line_debounce_enable & st.sync2);

  // ****************************************
  // mode, alternatives and events
  // ****************************************
  logic [6:0] sec;
  logic [6:0] plain;
  logic [6:0] alt_drv;
  logic [6:0] alt_lvl;
  logic [6:0] alt_od;
  logic [6:0] rise;
  logic [6:0] fall;
  logic [6:0] ev;
  logic [6:0] ev_set;
  logic [6:0] wake_src;

  assign sec   = pad_function_select_a;
  assign plain = ~sec & {NL{gpio_enable}};
  assign rise  = filt & ~st.prev;
  assign fall  = ~filt & st.prev;
  assign ev    = plain & ((rise & irq_rise_enable)
                        | (fall & irq_fall_enable));
  assign ev_set = ev & ~irq_mask;
  assign wake_src = ev & wake_enable
                  & ~(off_mode ? VIO_LINES : 7'h00);

  always_comb begin
    alt_drv = 7'h00;
    alt_lvl = 7'h00;
    alt_od  = alt_open_drain;
    // supply enables follow the power-up sequencer
    if (alt_is(sec, pad_function_select_b, 0, A0_EXT_A)) begin
      alt_drv[0] = 1'b1;
      alt_lvl[0] = ext_supply_en_a;
    end
    if (alt_is(sec, pad_function_select_b, 2, A2_LINK_DA)) begin
      alt_drv[2] = 1'b1;
      alt_lvl[2] = ~scaling_link_data_oe;
      alt_od[2]  = 1'b1;
    end
    if (alt_is(sec, pad_function_select_b, 3, A3_EXT_A)) begin
      alt_drv[3] = 1'b1;
      alt_lvl[3] = ext_supply_en_a;
    end
    if (alt_is(sec, pad_function_select_b, 4, A4_EXT_B)) begin
      alt_drv[4] = 1'b1;
      alt_lvl[4] = ext_supply_en_b;
    end
    if (alt_is(sec, pad_function_select_b, 5, A5_EXT_C)) begin
      alt_drv[5] = 1'b1;
      alt_lvl[5] = ext_supply_en_c;
    end
    if (alt_is(sec, pad_function_select_b, 6, A6_VALID)) begin
      alt_drv[6] = 1'b1;
      alt_lvl[6] = supplies_valid_out;
    end else if (alt_is(sec, pad_function_select_b, 6, A6_EXT_C)) begin
      alt_drv[6] = 1'b1;
      alt_lvl[6] = ext_supply_en_c;
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.sync1 = pad_in;
    next_st.sync2 = st.sync1;
    next_st.prev  = filt;
    next_st.tick_cnt = tick ? '0 : st.tick_cnt + 1'b1;

    // write wins, then clear, then set
    if (line_out_wr_en) begin
      next_st.out_data = line_out_wr_data;
    end else begin
      next_st.out_data = (st.out_data | line_out_set) & ~line_out_clear;
    end

    next_st.in_state = filt & plain & ~line_direction;
    // a new event beats a clear in the same cycle
    next_st.status = (st.status & ~irq_clear) | ev_set;
    next_st.wake   = |wake_src;

    for (int i = 0; i < NL; i++) begin
      if (sec[i]) begin
        // plain controls ignored here
        next_st.pull_up[i] = alt_pull_up[i];
        next_st.pull_dn[i] = alt_pull_down[i];
        if (alt_od[i]) begin
          next_st.drv_out[i] = 1'b0;
          next_st.drv_oe[i]  = alt_drv[i] & ~alt_lvl[i];
        end else begin
          next_st.drv_out[i] = alt_lvl[i];
          next_st.drv_oe[i]  = alt_drv[i];
        end
      end else if (plain[i]) begin
        next_st.pull_up[i] = line_pull_config_a[i];
        next_st.pull_dn[i] = line_pull_config_b[i];
        if (!line_direction[i]) begin
          next_st.drv_out[i] = 1'b0;
          next_st.drv_oe[i]  = 1'b0;
        end else if (line_open_drain_enable[i]) begin
          next_st.drv_out[i] = 1'b0;
          next_st.drv_oe[i]  = ~st.out_data[i];
        end else begin
          next_st.drv_out[i] = st.out_data[i];
          next_st.drv_oe[i]  = 1'b1;
        end
      end else begin
        next_st.pull_up[i] = 1'b0;
        next_st.pull_dn[i] = 1'b0;
        next_st.drv_out[i] = 1'b0;
        next_st.drv_oe[i]  = 1'b0;
      end
    end

    // alternative inputs to the core, idle when not selected
    next_st.pwr_off = alt_is(sec, pad_function_select_b, 0, A0_PWR_OFF)
                    & st.sync2[0];
    next_st.preq_b  = (alt_is(sec, pad_function_select_b, 0, A0_PREQ_B) & st.sync2[0])
                    | (alt_is(sec, pad_function_select_b, 2, A2_PREQ_B)
                       & st.sync2[2]);
    next_st.rst_in  = alt_is(sec, pad_function_select_b, 1, A1_RESET)
                    & st.sync2[1];
    next_st.warm_n  = ~alt_is(sec, pad_function_select_b, 1, A1_WARM)
                    | st.sync2[1];
    next_st.bus_det = alt_is(sec, pad_function_select_b, 1, A1_BUS_DET)
                    & st.sync2[1];
    next_st.preq_a  = alt_is(sec, pad_function_select_b, 1, A1_PREQ_A)
                    & st.sync2[1];
    next_st.link_da = ~alt_is(sec, pad_function_select_b, 2, A2_LINK_DA)
                    | st.sync2[2];
    next_st.sync_in = alt_is(sec, pad_function_select_b, 3, A3_SYNC)
                    & st.sync2[3];
    next_st.link_ck = ~alt_is(sec, pad_function_select_b, 4, A4_LINK_CK)
                    | st.sync2[4];
    next_st.keep_on = alt_is(sec, pad_function_select_b, 5, A5_KEEP_ON)
                    & st.sync2[5];
    next_st.sleep_n = ~alt_is(sec, pad_function_select_b, 6, A6_SLEEP)
                    | st.sync2[6];
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st          <= '0;
      st.out_data <= OUT_RST;
      st.warm_n   <= 1'b1;
      st.sleep_n  <= 1'b1;
      st.link_da  <= 1'b1;
      st.link_ck  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign pad_out              = st.drv_out;
  assign pad_oe               = st.drv_oe;
  assign pad_pull_up          = st.pull_up;
  assign pad_pull_down        = st.pull_dn;
  assign line_out_state       = st.out_data;
  assign line_in_state        = st.in_state;
  assign irq_status           = st.status;
  assign wake_request         = st.wake;
  assign scaling_link_data    = st.link_da;
  assign scaling_link_clock   = st.link_ck;
  assign power_off_request_in = st.pwr_off;
  assign periph_power_req_a   = st.preq_a;
  assign periph_power_req_b   = st.preq_b;
  assign reset_in             = st.rst_in;
  assign warm_reset_in_n      = st.warm_n;
  assign bus_supply_detect_in = st.bus_det;
  assign converter_sync_in    = st.sync_in;
  assign keep_on_in           = st.keep_on;
  assign sleep_request_in_n   = st.sleep_n;

  // ****************************************
  // checks
  // ****************************************
  logic [6:0] set_and_clr;
  logic [6:0] plain_in;
  logic       only_vio;

  assign set_and_clr = ev_set & irq_clear;
  assign plain_in    = plain & ~line_direction;
  assign only_vio    = ((ev & wake_enable & ~VIO_LINES) == 7'h00);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_status_set_wins: assert property (
    (set_and_clr != 7'h00) |=> ((irq_status & $past(set_and_clr)) == $past(set_and_clr))
  ) else $error("event lost against clear");

  a_status_cause: assert property (
    ((irq_status & ~$past(irq_status) & ~$past(ev_set)) == 7'h00)
  ) else $error("status bit set with no unmasked event");

  a_alt_no_irq: assert property (
    ((irq_status & ~$past(irq_status) & ~$past(plain)) == 7'h00)
  ) else $error("status set on line not in plain mode");

  a_out_set_bits: assert property (
    (!line_out_wr_en && line_out_clear == 7'h00)
    |=> (line_out_state == ($past(line_out_state) | $past(line_out_set)))
  ) else $error("set bits not applied");

  a_out_clr_bits: assert property (
    (!line_out_wr_en && line_out_set == 7'h00)
    |=> (line_out_state == ($past(line_out_state) & ~$past(line_out_clear)))
  ) else $error("clear bits not applied");

  a_off_wake_block: assert property (
    (off_mode && only_vio) |=> !wake_request
  ) else $error("io supply line woke device from off");

  a_plain_in_float: assert property (
    (plain_in != 7'h00) |=> ((pad_oe & $past(plain_in)) == 7'h00)
  ) else $error("input line driven");

  a_seq_drive: assert property (
    (alt_is(sec, pad_function_select_b, 3, A3_EXT_A) && !alt_open_drain[3] && ext_supply_en_a)
    |=> (pad_oe[3] && pad_out[3])
  ) else $error("supply enable a not driven on line 3");

endmodule // pgmp_port

/* common/pgmp_pkg.sv */
// constants shared by the multiplexed general-purpose line port
package pgmp_pkg;

  // ****************************************
  // port shape
  // ****************************************
  localparam int NL    = 7;
  localparam int SEL_W = 2;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ      = 25;
  localparam int DEB_TIME_US  = 1000;
  localparam int DEB_SAMPLES  = 4;
  localparam int DEB_TICK_CYC = DEB_TIME_US * CLK_MHZ / DEB_SAMPLES;
  localparam int TICK_W       = 16;

  // ****************************************
  // reset values and line groups
  // ****************************************
  localparam logic [6:0] OUT_RST   = 7'h00;
  localparam logic [6:0] VIO_LINES = 7'h14;

  // ****************************************
  // alternative function codes, per line
  // ****************************************
  localparam logic [1:0] A0_PWR_OFF = 2'h0;
  localparam logic [1:0] A0_PREQ_B  = 2'h1;
  localparam logic [1:0] A0_EXT_A   = 2'h2;
  localparam logic [1:0] A1_RESET   = 2'h0;
  localparam logic [1:0] A1_WARM    = 2'h1;
  localparam logic [1:0] A1_BUS_DET = 2'h2;
  localparam logic [1:0] A1_PREQ_A  = 2'h3;
  localparam logic [1:0] A2_LINK_DA = 2'h0;
  localparam logic [1:0] A2_PREQ_B  = 2'h1;
  localparam logic [1:0] A3_EXT_A   = 2'h0;
  localparam logic [1:0] A3_SYNC    = 2'h1;
  localparam logic [1:0] A4_EXT_B   = 2'h0;
  localparam logic [1:0] A4_LINK_CK = 2'h1;
  localparam logic [1:0] A5_KEEP_ON = 2'h0;
  localparam logic [1:0] A5_EXT_C   = 2'h1;
  localparam logic [1:0] A6_SLEEP   = 2'h0;
  localparam logic [1:0] A6_VALID   = 2'h1;
  localparam logic [1:0] A6_EXT_C   = 2'h2;

endpackage

/* design/pgmp_debounce.sv */
// one-line input debounce filter driven by a sample tick
`timescale 1ns/1ps
module pgmp_debounce #(
  parameter int SAMPLES = pgmp_pkg::DEB_SAMPLES
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic tick,
  input  wire logic raw,
  output logic      level
);
  import pgmp_pkg::*;

  localparam int CW = $clog2(SAMPLES + 1);
  localparam logic [CW-1:0] LAST = CW'(SAMPLES - 1);

  generate
    if (SAMPLES < 2) begin : g_bad
      $error("debounce needs at least two samples");
    end
  endgenerate

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          lvl;
  } pgmp_deb_st_t;

  pgmp_deb_st_t st;
  pgmp_deb_st_t next_st;

  always_comb begin
    next_st = st;
    if (raw == st.lvl) begin
      next_st.cnt = '0;
    end else if (tick) begin
      // new level must hold for a full run of samples
      if (st.cnt == LAST) begin
        next_st.lvl = raw;
        next_st.cnt = '0;
      end else begin
        next_st.cnt = st.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.lvl;

endmodule // pgmp_debounce

/* sim/pgmp_pad_model.sv */
// pad-side model: host processor and external regulators on the seven lines
`timescale 1ns/1ps
module pgmp_pad_model (
  input  wire logic       sys_clk,
  input  wire logic [6:0] pad_out,
  input  wire logic [6:0] pad_oe,
  input  wire logic [6:0] pad_pull_up,
  input  wire logic [6:0] pad_pull_down,
  input  wire logic [6:0] host_en,
  input  wire logic [6:0] host_val,
  output logic      [6:0] pad_in
);
  logic flip = 1'h0;

  // undriven, unpulled lines wander every cycle
  always @(posedge sys_clk) flip <= ~flip;

  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (host_en[i]) pad_in[i] = host_val[i];
      else if (pad_pull_up[i]) pad_in[i] = 1'h1;
      else if (pad_pull_down[i]) pad_in[i] = 1'h0;
      else pad_in[i] = flip ^ i[0];
    end
  end
endmodule // pgmp_pad_model

/* sim/tb.sv */
// self-checking bench for the multiplexed general-purpose line port
`timescale 1ns/1ps
module tb;
  import pgmp_pkg::*;
  logic        sys_clk = 1'h0;
  logic        rst = 1'h1;
  logic [6:0]  pad_function_select_a, line_direction, line_out_wr_data, line_out_set;
  logic [6:0]  line_out_clear, line_debounce_enable, line_pull_config_a, line_pull_config_b;
  logic [6:0]  line_open_drain_enable, alt_pull_up, alt_pull_down, alt_open_drain;
  logic [6:0]  irq_rise_enable, irq_fall_enable, irq_mask, irq_clear, wake_enable;
  logic [6:0]  host_en, host_val;
  logic [13:0] pad_function_select_b;
  logic [3:0]  core;
  logic        gpio_enable, line_out_wr_en, off_mode, scaling_link_data_oe;
  logic [6:0]  pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_down;
  logic [6:0]  line_out_state, line_in_state, irq_status;
  logic        wake_request, scaling_link_data, scaling_link_clock, power_off_request_in;
  logic        periph_power_req_a, periph_power_req_b, reset_in, warm_reset_in_n;
  logic        bus_supply_detect_in, converter_sync_in, keep_on_in, sleep_request_in_n;
  logic [10:0] alt_in;
  int          miscompares = 0;
  int          comparisons = 0;
  int          wakes = 0;

  assign alt_in = {scaling_link_data, scaling_link_clock, sleep_request_in_n, keep_on_in,
                   converter_sync_in, bus_supply_detect_in, warm_reset_in_n, reset_in,
                   periph_power_req_b, periph_power_req_a, power_off_request_in};

  pgmp_port #(.DEB_TICK_CYCLES(2)) dut (
    .sys_clk, .rst, .pad_in, .pad_out, .pad_oe, .pad_pull_up, .pad_pull_down,
    .pad_function_select_a, .pad_function_select_b, .gpio_enable, .line_direction,
    .line_out_wr_en, .line_out_wr_data, .line_out_set, .line_out_clear, .line_out_state,
    .line_in_state, .line_debounce_enable, .line_pull_config_a, .line_pull_config_b,
    .line_open_drain_enable, .alt_pull_up, .alt_pull_down, .alt_open_drain,
    .irq_rise_enable, .irq_fall_enable, .irq_mask, .irq_clear, .irq_status, .wake_enable,
    .off_mode, .wake_request, .ext_supply_en_a(core[0]), .ext_supply_en_b(core[1]),
    .ext_supply_en_c(core[2]), .supplies_valid_out(core[3]), .scaling_link_data_oe,
    .scaling_link_data, .scaling_link_clock, .power_off_request_in, .periph_power_req_a,
    .periph_power_req_b, .reset_in, .warm_reset_in_n, .bus_supply_detect_in,
    .converter_sync_in, .keep_on_in, .sleep_request_in_n
  );

  pgmp_pad_model model (
    .sys_clk, .pad_out, .pad_oe, .pad_pull_up, .pad_pull_down, .host_en, .host_val, .pad_in
  );

  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (wake_request === 1'h1) wakes++;

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string what, input logic [13:0] seen, input logic [13:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic sel(input int l, input logic [1:0] c);
    @(posedge sys_clk);
    pad_function_select_a <= 7'h01 << l;
    pad_function_select_b <= 14'(c) << (2 * l);
  endtask

  task automatic stop_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    @(negedge sys_clk);
    check("out_state", line_out_state, 7'h00);
    check("idle_high", {warm_reset_in_n, sleep_request_in_n, scaling_link_data,
                        scaling_link_clock}, 4'hF);
    check("pad_oe_rst", pad_oe, 7'h00);
    repeat (4) @(posedge sys_clk);
    rst <= 1'h0;
    $display("test reset done");
  endtask

  task automatic t_out;
    @(posedge sys_clk);
    gpio_enable <= 1'h1; line_direction <= 7'h7F; line_open_drain_enable <= 7'h01;
    line_pull_config_a <= 7'h0C; line_pull_config_b <= 7'h30;
    line_out_wr_en <= 1'h1; line_out_wr_data <= 7'h55;
    @(posedge sys_clk);
    line_out_wr_en <= 1'h0; line_out_set <= 7'h03; line_out_clear <= 7'h01;
    @(posedge sys_clk);
    line_out_set <= 7'h00; line_out_clear <= 7'h00;
    @(negedge sys_clk);
    check("set_clear", line_out_state, 7'h56);
    @(posedge sys_clk);
    line_out_wr_en <= 1'h1; line_out_wr_data <= 7'h23; line_out_set <= 7'h40;
    @(posedge sys_clk);
    line_out_wr_en <= 1'h0; line_out_set <= 7'h00;
    wt(1);
    check("write", line_out_state, 7'h23);
    check("pad_out", pad_out, 7'h22);
    check("pad_oe", pad_oe, 7'h7E);
    check("pulls", {pad_pull_up, pad_pull_down}, 14'h0630);
    @(posedge sys_clk);
    gpio_enable <= 1'h0;
    wt(2);
    check("disabled", {pad_oe, pad_pull_up}, 14'h0000);
    @(posedge sys_clk);
    gpio_enable <= 1'h1; line_direction <= 7'h00;
    line_pull_config_a <= 7'h00; line_pull_config_b <= 7'h00;
    wt(3);
    $display("test output done");
  endtask

  task automatic t_in;
    int w;
    @(posedge sys_clk);
    irq_rise_enable <= 7'h0B; irq_fall_enable <= 7'h20; irq_mask <= 7'h08;
    wake_enable <= 7'h02; irq_clear <= 7'h7F;
    @(posedge sys_clk);
    irq_clear <= 7'h00;
    w = wakes;
    host_val <= 7'h2B;
    wt(2);
    check("early", irq_status, 7'h00);
    wt(0);
    @(posedge sys_clk);
    @(negedge sys_clk);
    check("in_state", line_in_state, 7'h2B);
    check("rise", irq_status, 7'h03);
    wt(2);
    check("wake", 14'(wakes - w), 14'h0001);
    @(posedge sys_clk);
    host_val <= 7'h00;
    repeat (2) @(posedge sys_clk);
    irq_clear <= 7'h20;
    @(posedge sys_clk);
    irq_clear <= 7'h00;
    @(negedge sys_clk);
    check("fall", irq_status, 7'h23);
    @(posedge sys_clk);
    irq_mask <= 7'h7F; irq_clear <= 7'h01;
    @(posedge sys_clk);
    irq_clear <= 7'h00;
    wt(1);
    check("mask_keep", irq_status, 7'h22);
    check("wake_fall", 14'(wakes - w), 14'h0001);
    $display("test input done");
  endtask

  task automatic t_off;
    int w;
    @(posedge sys_clk);
    irq_mask <= 7'h00; irq_rise_enable <= 7'h7F; irq_fall_enable <= 7'h00;
    wake_enable <= 7'h7F; off_mode <= 1'h1;
    w = wakes;
    @(posedge sys_clk);
    host_val <= 7'h14;
    wt(5);
    check("off_quiet", 14'(wakes - w), 14'h0000);
    @(posedge sys_clk);
    host_val <= 7'h15;
    wt(5);
    check("off_wake", 14'(wakes - w), 14'h0001);
    @(posedge sys_clk);
    off_mode <= 1'h0; host_val <= 7'h00;
    wt(5);
    @(posedge sys_clk);
    host_val <= 7'h04;
    wt(5);
    check("on_wake", 14'(wakes - w), 14'h0002);
    $display("test wake done");
  endtask

  task automatic t_deb;
    int n;
    @(posedge sys_clk);
    line_debounce_enable <= 7'h40; irq_clear <= 7'h7F; host_val <= 7'h00;
    @(posedge sys_clk);
    irq_clear <= 7'h00; host_val <= 7'h40;
    repeat (2) @(posedge sys_clk);
    host_val <= 7'h00;
    wt(20);
    check("glitch", {line_in_state[6], irq_status[6]}, 2'h0);
    @(posedge sys_clk);
    host_val <= 7'h40;
    wt(5);
    check("deb_wait", {line_in_state[6], irq_status[6]}, 2'h0);
    n = 0;
    while (line_in_state[6] !== 1'h1 && n < 40) begin
      wt(0);
      n++;
    end
    wt(1);
    check("deb_pass", {line_in_state[6], irq_status[6]}, 2'h3);
    $display("test debounce done");
  endtask

  task automatic t_alt;
    int         li[12] = '{0, 0, 1, 1, 1, 1, 2, 2, 3, 4, 5, 6};
    logic [1:0] ci[12] = '{A0_PWR_OFF, A0_PREQ_B, A1_RESET, A1_WARM, A1_BUS_DET, A1_PREQ_A,
                           A2_LINK_DA, A2_PREQ_B, A3_SYNC, A4_LINK_CK, A5_KEEP_ON, A6_SLEEP};
    int         xi[12] = '{0, 2, 3, 4, 5, 1, 10, 2, 6, 9, 7, 8};
    int         lo[6] = '{0, 3, 4, 5, 6, 6};
    logic [1:0] co[6] = '{A0_EXT_A, A3_EXT_A, A4_EXT_B, A5_EXT_C, A6_VALID, A6_EXT_C};
    int         xo[6] = '{0, 0, 1, 2, 3, 2};
    @(posedge sys_clk);
    line_debounce_enable <= 7'h00; host_val <= 7'h00; line_pull_config_a <= 7'h7F;
    alt_pull_down <= 7'h7F; irq_fall_enable <= 7'h7F;
    wt(4);
    @(posedge sys_clk);
    irq_clear <= 7'h7F;
    @(posedge sys_clk);
    irq_clear <= 7'h00;
    for (int k = 0; k < 12; k++) begin
      sel(li[k], ci[k]);
      host_val <= 7'h01 << li[k];
      wt(4);
      check("alt_in_hi", alt_in[xi[k]], 1'h1);
      check("alt_pull", {pad_pull_up[li[k]], pad_pull_down[li[k]]}, 2'h1);
      @(posedge sys_clk);
      host_val <= 7'h00;
      wt(4);
      check("alt_in_lo", alt_in[xi[k]], 1'h0);
    end
    sel(2, A2_LINK_DA);
    scaling_link_data_oe <= 1'h1;
    host_val <= 7'h04;
    wt(4);
    check("link_pull", {pad_oe[2], pad_out[2], scaling_link_data}, 3'h4);
    @(posedge sys_clk);
    scaling_link_data_oe <= 1'h0;
    host_val <= 7'h00;
    for (int k = 0; k < 6; k++) begin
      sel(lo[k], co[k]);
      core <= 4'h1 << xo[k];
      wt(2);
      check("alt_out_hi", {pad_oe[lo[k]], pad_out[lo[k]]}, 2'h3);
      @(posedge sys_clk);
      core <= 4'h0;
      wt(4);
      check("alt_out_lo", pad_out[lo[k]], 1'h0);
    end
    @(posedge sys_clk);
    pad_function_select_a <= 7'h00;
    wt(3);
    check("alt_quiet", irq_status, 7'h00);
    $display("test alternative done");
  endtask

  initial begin
    {pad_function_select_a, line_direction, line_out_wr_data, line_out_set} = '0;
    {line_out_clear, line_debounce_enable, line_pull_config_a, line_pull_config_b} = '0;
    {line_open_drain_enable, alt_pull_up, alt_pull_down, alt_open_drain} = '0;
    {irq_rise_enable, irq_fall_enable, irq_mask, irq_clear, wake_enable} = '0;
    {host_val, pad_function_select_b, core} = '0;
    {gpio_enable, line_out_wr_en, off_mode, scaling_link_data_oe} = '0;
    host_en = 7'h7F;
    t_reset;
    t_out;
    t_in;
    t_off;
    t_deb;
    t_alt;
    stop_test;
  end

  initial begin
    repeat (3000) @(posedge sys_clk);
    miscompares++;
    stop_test;
  end
endmodule // tb
